// ==== pkg/timer5_regs.vh ====
/*
 register offsets, field positions and reset values of the timer block.
 assumes a 16-bit register address space with 8-bit data.
*/
`ifndef TIMER5_REGS_VH
`define TIMER5_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define T5_ADDR_CTRL        16'ha003
`define T5_ADDR_COUNT_LO    16'ha004
`define T5_ADDR_COUNT_MID   16'ha005
`define T5_ADDR_COUNT_HI    16'ha006
`define T5_ADDR_RELOAD_LO   16'ha007
`define T5_ADDR_RELOAD_MID  16'ha008
`define T5_ADDR_RELOAD_HI   16'ha009
`define T5_ADDR_IRQ_STATUS  16'ha00a
`define T5_ADDR_IRQ_CLEAR   16'ha00b
`define T5_ADDR_IRQ_ENABLE  16'ha00c

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define T5_BIT_OVF_FLAG     7
`define T5_BIT_SEL_HI       6
`define T5_BIT_SEL_LO       5
`define T5_BIT_MODE         4
`define T5_BIT_RUN          3
`define T5_BIT_IRQ_EN       0

// ----------------------------------------------------------------------
// event status fields
// ----------------------------------------------------------------------
`define T5_EVT_OVERFLOW     0
`define T5_EVT_WIDTH        1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define T5_RST_CTRL         8'h00
`define T5_RST_COUNT        24'h000000
`define T5_RST_RELOAD       24'h000000
`define T5_RST_EVT          1'b0

`endif

// ==== tb/timer5_checker.sv ====
/*
 port checker for the timer block: read port, flag and interrupt relations.
 assumes it is bound to timer5_control_status and sees mclk and sys_rst.
*/
`timescale 1ns/100ps
`include "timer5_regs.vh"
module timer5_checker
(
   // clock and reset
   input wire        mclk,
   input wire        sys_rst,
   // register port
   input wire [15:0] reg_addr,
   input wire [7:0]  reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [7:0]  reg_rdata,
   // interrupts
   input wire        overflow_irq,
   input wire        event_irq
);
   wire ctrl_wr = reg_wr && reg_addr == `T5_ADDR_CTRL;
   wire ctrl_rd = reg_rd && reg_addr == `T5_ADDR_CTRL;
   wire en_wr   = reg_wr && reg_addr == `T5_ADDR_IRQ_ENABLE;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------------
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   chk_reserved_zero: assert property (ctrl_rd |=> reg_rdata[2:1] == 2'b00)
      else $error("unused control bits read nonzero");
   chk_unmapped_zero: assert property (reg_rd && reg_addr == 16'ha00d |=> reg_rdata == 8'h00)
      else $error("unmapped read nonzero");
   chk_flag_read: assert property (ctrl_rd && overflow_irq |=> reg_rdata[7] && reg_rdata[0])
      else $error("irq high without flag and enable");
   chk_irq_masked: assert property (ctrl_wr && !reg_wdata[0] |=> !overflow_irq)
      else $error("overflow irq while disabled");
   chk_flag_sticky: assert property ($fell(overflow_irq) |-> $past(ctrl_wr))
      else $error("overflow irq dropped without write");
   chk_status_sticky: assert property ($fell(event_irq) |->
      $past(en_wr || (reg_wr && reg_addr == `T5_ADDR_IRQ_CLEAR)))
      else $error("event irq dropped without write");
   chk_event_masked: assert property (en_wr && !reg_wdata[0] |=> !event_irq)
      else $error("event irq while disabled");
   chk_status_read: assert property (reg_rd && reg_addr == `T5_ADDR_IRQ_STATUS && event_irq
      |=> reg_rdata[0])
      else $error("event irq without status bit");
endmodule
bind timer5_control_status timer5_checker i_chk (.mclk(mclk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .overflow_irq(overflow_irq), .event_irq(event_irq));

// ==== tb/timer5_control_status_tb.sv ====
/*
 self-checking bench for the timer block.
 assumes the bench drives the register port and both oscillator pins.
*/
`timescale 1ns/100ps
`include "timer5_regs.vh"
module timer5_control_status_tb;
   reg         mclk = 1'b0;
   reg         sys_rst = 1'b1;
   reg  [15:0] reg_addr = 16'h0000;
   reg  [7:0]  reg_wdata = 8'h00;
   reg         reg_wr = 1'b0;
   reg         reg_rd = 1'b0;
   reg         internal_oscillator = 1'b0;
   reg         secondary_oscillator = 1'b0;
   wire [7:0]  reg_rdata;
   wire        overflow_irq;
   wire        event_irq;
   integer     n_mismatch = 0;
   integer     total_checks = 0;
   integer     i;
   always #2 mclk = ~mclk;
   timer5_control_status i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .internal_oscillator(internal_oscillator), .secondary_oscillator(secondary_oscillator),
      .overflow_irq(overflow_irq), .event_irq(event_irq));
   task chk(input [7:0] got, input [7:0] exp);
   begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         $display("ERROR %0t: got %h want %h", $time, got, exp);
         n_mismatch = n_mismatch + 1;
      end
   end
   endtask
   task wr(input [15:0] a, input [7:0] v);
   begin
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
      // step off the edge so callers see the written state settled
      #1;
   end
   endtask
   task rc(input [15:0] a, input [7:0] e);
   begin
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   end
   endtask
   task w3(input [15:0] a, input [23:0] v);
   begin
      wr(a, v[7:0]);
      wr(a + 16'h0001, v[15:8]);
      wr(a + 16'h0002, v[23:16]);
   end
   endtask
   task r3(input [23:0] e);
   begin
      rc(`T5_ADDR_COUNT_LO, e[7:0]);
      rc(`T5_ADDR_COUNT_MID, e[15:8]);
      rc(`T5_ADDR_COUNT_HI, e[23:16]);
   end
   endtask
   // one rising edge on a pin, then time for the tick to land
   task pulse(input p);
   begin
      @(posedge mclk);
      if (p) secondary_oscillator <= 1'b1;
      else internal_oscillator <= 1'b1;
      repeat (8) @(posedge mclk);
      secondary_oscillator <= 1'b0;
      internal_oscillator <= 1'b0;
      repeat (8) @(posedge mclk);
   end
   endtask
   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task t_reset;
   begin
      rc(`T5_ADDR_CTRL, 8'h00);
      r3(24'h000000);
      rc(16'ha00d, 8'h00);
      rc(`T5_ADDR_IRQ_CLEAR, 8'h00);
      wr(`T5_ADDR_CTRL, 8'hff);
      rc(`T5_ADDR_CTRL, 8'h79);
   end
   endtask
   task t_sel;
   begin
      for (i = 0; i < 4; i = i + 1)
      begin
         w3(`T5_ADDR_COUNT_LO, 24'h000000);
         wr(`T5_ADDR_CTRL, {1'b0, i[1:0], 5'h08});
         pulse(1'b0);
         rc(`T5_ADDR_COUNT_LO, (i < 2) ? 8'h01 : 8'h00);
         pulse(1'b1);
         rc(`T5_ADDR_COUNT_LO, 8'h01);
      end
   end
   endtask
   task t_run;
   begin
      wr(`T5_ADDR_CTRL, 8'h00);
      w3(`T5_ADDR_COUNT_LO, 24'h5a3c96);
      pulse(1'b0);
      r3(24'h5a3c96);
   end
   endtask
   task t_wrap;
   begin
      w3(`T5_ADDR_COUNT_LO, 24'hffffff);
      wr(`T5_ADDR_CTRL, 8'h09);
      pulse(1'b0);
      r3(24'h000000);
      rc(`T5_ADDR_CTRL, 8'h89);
      chk({7'h00, overflow_irq}, 8'h01);
      pulse(1'b0);
      rc(`T5_ADDR_CTRL, 8'h89);
      wr(`T5_ADDR_CTRL, 8'h88);
      chk({7'h00, overflow_irq}, 8'h00);
      wr(`T5_ADDR_CTRL, 8'h89);
      rc(`T5_ADDR_CTRL, 8'h89);
      wr(`T5_ADDR_CTRL, 8'h09);
      chk({7'h00, overflow_irq}, 8'h00);
      chk({7'h00, event_irq}, 8'h00);
      wr(`T5_ADDR_IRQ_ENABLE, 8'h01);
      chk({7'h00, event_irq}, 8'h01);
      rc(`T5_ADDR_IRQ_STATUS, 8'h01);
      wr(`T5_ADDR_IRQ_ENABLE, 8'h00);
      chk({7'h00, event_irq}, 8'h00);
      wr(`T5_ADDR_IRQ_ENABLE, 8'h01);
      wr(`T5_ADDR_IRQ_CLEAR, 8'h01);
      rc(`T5_ADDR_IRQ_STATUS, 8'h00);
   end
   endtask
   task t_reload;
   begin
      wr(`T5_ADDR_CTRL, 8'h00);
      w3(`T5_ADDR_COUNT_LO, 24'hffffff);
      w3(`T5_ADDR_RELOAD_LO, 24'h123456);
      wr(`T5_ADDR_CTRL, 8'h58);
      pulse(1'b0);
      pulse(1'b1);
      r3(24'h123456);
      rc(`T5_ADDR_CTRL, 8'hd8);
      chk({7'h00, event_irq}, 8'h01);
   end
   endtask
   task results;
   begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   initial
   begin
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset;
      t_sel;
      t_run;
      t_wrap;
      t_reload;
      results;
   end
   initial
   begin
      repeat (5000) @(posedge mclk);
      n_mismatch = n_mismatch + 1;
      results;
   end
endmodule

// ==== verilog/osc_tick_sync.v ====
/*
 brings one free-running oscillator pin into the mclk domain and turns
 each rising edge into a one-cycle tick.
 assumes the oscillator runs well below half the mclk rate.
*/
`timescale 1ns/100ps

module osc_tick_sync
(
   // clock and reset
   input  wire mclk,
   input  wire sys_rst,
   // oscillator pin
   input  wire osc_pin,
   // tick in mclk domain
   output wire osc_tick
);

   reg  sync_a_reg;
   reg  sync_b_reg;
   reg  last_reg;

   // ----------------------------------------------------------------------
   // two-flop synchroniser and edge detect
   // ----------------------------------------------------------------------
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         sync_a_reg <= 1'b0;
         sync_b_reg <= 1'b0;
         last_reg   <= 1'b0;
      end
      else
      begin
         sync_a_reg <= osc_pin;
         sync_b_reg <= sync_a_reg;
         last_reg   <= sync_b_reg;
      end
   end

   assign osc_tick = sync_b_reg & ~last_reg;

endmodule

// ==== verilog/timer5_control_status.v ====
/*
 fifth general timer: control/status register, 24-bit counter with
 auto-reload, oscillator select and interrupt logic.
 assumes a single-cycle register port master on mclk, and oscillator
 pins asynchronous to mclk.
*/
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "timer5_regs.vh"

module timer5_control_status
#(
   parameter COUNT_WIDTH = 24
)
(
   // clock and reset
   input  wire        mclk,
   input  wire        sys_rst,
   // register port
   input  wire [15:0] reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   // oscillator pins
   input  wire        internal_oscillator,
   input  wire        secondary_oscillator,
   // interrupts
   output wire        overflow_irq,
   output wire        event_irq
);

   localparam [COUNT_WIDTH-1:0] COUNT_MAX = {COUNT_WIDTH{1'b1}};

   // ----------------------------------------------------------------------
   // write decode helper
   // ----------------------------------------------------------------------
   function wr_hit;
      input        wr;
      input [15:0] addr;
      input [15:0] target;
      begin
         wr_hit = wr & (addr == target);
      end
   endfunction

   wire [1:0]             osc_pins;
   wire [1:0]             osc_ticks;
   wire                   count_tick;
   wire                   overflow_now;

   reg                    overflow_flag_reg;
   reg  [1:0]             clock_source_select_reg;
   reg                    reload_mode_select_reg;
   reg                    run_control_reg;
   reg                    overflow_irq_enable_reg;
   reg  [23:0]            count_value_reg;
   reg  [23:0]            count_value_next;
   reg  [23:0]            reload_value_reg;
   reg  [`T5_EVT_WIDTH-1:0] evt_status_reg;
   reg  [`T5_EVT_WIDTH-1:0] evt_enable_reg;
   reg  [7:0]             rdata_next;

   // ----------------------------------------------------------------------
   // oscillator tick synchronisers
   // ----------------------------------------------------------------------
   assign osc_pins = {secondary_oscillator, internal_oscillator};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_osc
         osc_tick_sync u_sync
         (
            .mclk     (mclk),
            .sys_rst  (sys_rst),
            .osc_pin  (osc_pins[gi]),
            .osc_tick (osc_ticks[gi])
         );
      end
   endgenerate

   // high select bit picks the secondary source
   assign count_tick = (clock_source_select_reg[1] ? osc_ticks[1] : osc_ticks[0])
                       & run_control_reg;

   assign overflow_now = count_tick & (count_value_reg == COUNT_MAX);

   // ----------------------------------------------------------------------
   // counter next value
   // ----------------------------------------------------------------------
   always @*
   begin
      count_value_next = count_value_reg;
      if (overflow_now)
      begin
         if (reload_mode_select_reg)
            count_value_next = reload_value_reg;
         else
            count_value_next = `T5_RST_COUNT;
      end
      else if (count_tick)
      begin
         count_value_next = count_value_reg + 24'h000001;
      end
      // a firmware byte write overrides the count in that byte
      if (wr_hit(reg_wr, reg_addr, `T5_ADDR_COUNT_LO))
         count_value_next[7:0] = reg_wdata;
      if (wr_hit(reg_wr, reg_addr, `T5_ADDR_COUNT_MID))
         count_value_next[15:8] = reg_wdata;
      if (wr_hit(reg_wr, reg_addr, `T5_ADDR_COUNT_HI))
         count_value_next[23:16] = reg_wdata;
   end

   // ----------------------------------------------------------------------
   // control, counter and reload registers
   // ----------------------------------------------------------------------
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         overflow_flag_reg       <= 1'b0;
         clock_source_select_reg <= 2'h0;
         reload_mode_select_reg  <= 1'b0;
         run_control_reg         <= 1'b0;
         overflow_irq_enable_reg <= 1'b0;
         count_value_reg         <= `T5_RST_COUNT;
         reload_value_reg        <= `T5_RST_RELOAD;
      end
      else
      begin
         count_value_reg <= count_value_next;
         if (wr_hit(reg_wr, reg_addr, `T5_ADDR_CTRL))
         begin
            clock_source_select_reg <= reg_wdata[`T5_BIT_SEL_HI:`T5_BIT_SEL_LO];
            reload_mode_select_reg  <= reg_wdata[`T5_BIT_MODE];
            run_control_reg         <= reg_wdata[`T5_BIT_RUN];
            overflow_irq_enable_reg <= reg_wdata[`T5_BIT_IRQ_EN];
         end
         // set wins; only a firmware write of zero clears
         if (overflow_now)
            overflow_flag_reg <= 1'b1;
         else if (wr_hit(reg_wr, reg_addr, `T5_ADDR_CTRL) & ~reg_wdata[`T5_BIT_OVF_FLAG])
            overflow_flag_reg <= 1'b0;
         if (wr_hit(reg_wr, reg_addr, `T5_ADDR_RELOAD_LO))
            reload_value_reg[7:0] <= reg_wdata;
         if (wr_hit(reg_wr, reg_addr, `T5_ADDR_RELOAD_MID))
            reload_value_reg[15:8] <= reg_wdata;
         if (wr_hit(reg_wr, reg_addr, `T5_ADDR_RELOAD_HI))
            reload_value_reg[23:16] <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------------
   // event status, clear and enable
   // ----------------------------------------------------------------------
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         evt_status_reg <= `T5_RST_EVT;
         evt_enable_reg <= `T5_RST_EVT;
      end
      else
      begin
         if (wr_hit(reg_wr, reg_addr, `T5_ADDR_IRQ_ENABLE))
            evt_enable_reg <= reg_wdata[`T5_EVT_WIDTH-1:0];
         if (overflow_now)
            evt_status_reg[`T5_EVT_OVERFLOW] <= 1'b1;
         else if (wr_hit(reg_wr, reg_addr, `T5_ADDR_IRQ_CLEAR)
                  & reg_wdata[`T5_EVT_OVERFLOW])
            evt_status_reg[`T5_EVT_OVERFLOW] <= 1'b0;
      end
   end

   assign overflow_irq = overflow_irq_enable_reg & overflow_flag_reg;
   assign event_irq    = |(evt_status_reg & evt_enable_reg);

   // ----------------------------------------------------------------------
   // read path, data one cycle after the strobe
   // ----------------------------------------------------------------------
   always @*
   begin
      rdata_next = 8'h00;
      case (reg_addr)
         `T5_ADDR_CTRL:
            rdata_next = {overflow_flag_reg, clock_source_select_reg,
                          reload_mode_select_reg, run_control_reg,
                          2'b00, overflow_irq_enable_reg};
         `T5_ADDR_COUNT_LO:   rdata_next = count_value_reg[7:0];
         `T5_ADDR_COUNT_MID:  rdata_next = count_value_reg[15:8];
         `T5_ADDR_COUNT_HI:   rdata_next = count_value_reg[23:16];
         `T5_ADDR_RELOAD_LO:  rdata_next = reload_value_reg[7:0];
         `T5_ADDR_RELOAD_MID: rdata_next = reload_value_reg[15:8];
         `T5_ADDR_RELOAD_HI:  rdata_next = reload_value_reg[23:16];
         `T5_ADDR_IRQ_STATUS: rdata_next = {7'h00, evt_status_reg};
         `T5_ADDR_IRQ_ENABLE: rdata_next = {7'h00, evt_enable_reg};
         default:             rdata_next = 8'h00;
      endcase
   end

   always @(posedge mclk)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rdata_next;
      else
         reg_rdata <= 8'h00;
   end

endmodule
